// File: include/asc_pkg.sv
// Package: register map, field layout and timing for the converter sequencer
package asc_pkg;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam int          RES_W        = 10;
    localparam int          NUM_PAIRS    = 4;
    localparam int          CH_W         = 3;
    // Register byte offsets
    localparam logic [7:0]  OFF_MODE_A   = 8'h00;
    localparam logic [7:0]  OFF_MODE_B   = 8'h04;
    localparam logic [7:0]  OFF_PAIR0    = 8'h08;
    localparam logic [7:0]  OFF_PAIR1    = 8'h0C;
    localparam logic [7:0]  OFF_PAIR2    = 8'h10;
    localparam logic [7:0]  OFF_PAIR3    = 8'h14;
    // converter_mode_reg_a fields
    localparam int          A_START      = 0;
    localparam int          A_SCAN       = 1;
    localparam int          A_REPEAT     = 2;
    localparam int          A_ITM        = 3;
    localparam int          A_BUSY       = 6;
    localparam int          A_EOC        = 7;
    // converter_mode_reg_b fields
    localparam int          B_CH_LSB     = 0;
    localparam int          B_TRIG_EN    = 5;
    localparam int          B_REF_EN     = 7;
    // Result word: result bits 9:2 at [15:8], bits 1:0 at [7:6], pad ones at [5:1], stored flag at [0]
    localparam int          R_HIGH_LSB   = 8;
    localparam int          R_LOW_LSB    = 6;
    localparam logic [4:0]  R_PAD_ONES   = 5'h1F;
    localparam int          R_PAD_LSB    = 1;
    localparam int          R_FLAG       = 0;
    // Reset values
    localparam logic [2:0]  CH_RESET     = 3'h0;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    // Clock states per channel
    localparam int          CONV_STATES  = 84;
    localparam int          CNT_W        = 7;
    // Fixed repeat mode with the timing bit set interrupts on every fourth result
    localparam logic [1:0]  ROT_LAST     = 2'h3;
endpackage : asc_pkg

// File: include/asc_conv_if.sv
// Interface between the sequencer and the conversion timer
`timescale 1ns/1ns
`default_nettype none
interface asc_conv_if;
    import asc_pkg::*;
    logic                 start;
    logic                 abort;
    logic [CH_W-1:0]      channel;
    logic [CH_W-1:0]      active_ch;
    logic                 sampling;
    logic                 done;
    logic [RES_W-1:0]     result;
    modport seq   (output start, output abort, output channel,
                   input active_ch, input sampling, input done, input result);
    modport timer (input start, input abort, input channel,
                   output active_ch, output sampling, output done, output result);
endinterface : asc_conv_if
`default_nettype wire

// File: verilog/asc_conv_timer.sv
// Conversion timer: paces one channel and captures the result
`timescale 1ns/1ns
`default_nettype none
module asc_conv_timer #(
    parameter int STATES = asc_pkg::CONV_STATES
) (
    // Clock and reset
    input  wire logic            core_clk,
    input  wire logic            rstn,
    // Sequencer side
    asc_conv_if.timer            conv,
    // Analogue core result
    input  wire logic [asc_pkg::RES_W-1:0] core_data
);
    import asc_pkg::*;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(STATES - 1);

    typedef struct packed {
        logic                active;
        logic [CNT_W-1:0]    cnt;
        logic [CH_W-1:0]     ch;
        logic                done;
        logic [RES_W-1:0]    result;
    } asc_tmr_s;

    asc_tmr_s s_reg;
    asc_tmr_s s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        if (conv.abort) begin
            // Abort outranks start
            s_next.active = 1'b0;
        end else if (conv.start) begin
            s_next.active = 1'b1;
            s_next.cnt    = '0;
            s_next.ch     = conv.channel;
        end else if (s_reg.active) begin
            if (s_reg.cnt == LAST) begin
                s_next.active = 1'b0;
                s_next.done   = 1'b1;
                s_next.result = core_data;
            end else begin
                s_next.cnt = s_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign conv.active_ch = s_reg.ch;
    assign conv.sampling  = s_reg.active;
    assign conv.done      = s_reg.done;
    assign conv.result    = s_reg.result;
endmodule : asc_conv_timer
`default_nettype wire

// File: verilog/asc_sequencer.sv
// Converter sequencer top: registers, start logic, modes and result pairs
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Fixed mode converts the input numbered by the channel-select code.
// - Scan codes 0-3 scan from input 0, codes 4-7 from input 4, ascending.
// - Reset clears scan select and sets channel select to 000.
// - Start by writing start bit, or enabled falling edge on trigger input.
// - Busy flag set at start and held while converting.
// - Start written during conversion aborts and restarts from the beginning.
// - Trigger falling edges are ignored while converting.
// - Fixed single: convert once, set end flag, clear busy, interrupt.
// - Scan single: convert group once, set end flag, clear busy, interrupt.
// - Fixed repeat: convert continuously, end flag each result, busy held.
// - Fixed repeat interrupt every conversion, or every fourth when timing bit set.
// - Scan repeat: rescan forever, end flag and interrupt per scan, busy held.
// - Clearing repeat bit: finish current conversion, stop, clear busy.
// - Halt entry stops the converter at once, even mid conversion.
// - Halt release restarts repeat modes from first step; single modes stay stopped.
// - One channel conversion takes 84 clock states.
// - Result pairs are read only; writes leave them unchanged.
// - Fixed repeat stores results into pairs 0,1,2,3 in rotation.
// - Other modes store inputs n and n+4 in pair n.
// - Pair stored flag sets on store, clears on software read.
// - Reading any result also clears the end-of-conversion flag.
module asc_sequencer #(
    parameter int CONV_STATES = asc_pkg::CONV_STATES
) (
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rstn,
    // AXI4-Lite write address
    input  wire logic [asc_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output var  logic                          s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [asc_pkg::DATA_W-1:0]    s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output var  logic                          s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]                    s_axi_bresp,
    output var  logic                          s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [asc_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output var  logic                          s_axi_arready,
    // AXI4-Lite read data
    output var  logic [asc_pkg::DATA_W-1:0]    s_axi_rdata,
    output var  logic [1:0]                    s_axi_rresp,
    output var  logic                          s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Pins and system
    input  wire logic                          external_trigger_input_n,
    input  wire logic                          halt_request,
    // Analogue core
    input  wire logic [asc_pkg::RES_W-1:0]     core_data,
    output var  logic [asc_pkg::CH_W-1:0]      core_channel,
    output var  logic                          core_sample,
    output var  logic                          reference_switch_enable,
    // Event
    output var  logic                          conversion_end_interrupt
);
    import asc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_HALT
    } asc_run_e;

    typedef struct packed {
        // Bus
        logic                          awready;
        logic                          awhave;
        logic [ADDR_W-1:0]             awaddr;
        logic                          wready;
        logic                          whave;
        logic [DATA_W-1:0]             wdata;
        logic [3:0]                    wstrb;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          arready;
        logic                          rvalid;
        logic [DATA_W-1:0]             rdata;
        logic [1:0]                    rresp;
        // Mode registers
        logic                          scan;
        logic                          repeat_on;
        logic                          itm;
        logic                          busy;
        logic                          eoc;
        logic [CH_W-1:0]               ch_sel;
        logic                          trig_en;
        logic                          ref_en;
        // Results
        logic [NUM_PAIRS-1:0][RES_W-1:0] res;
        logic [NUM_PAIRS-1:0]          stored;
        // Sequencing
        asc_run_e                      run;
        logic [CH_W-1:0]               cur_ch;
        logic [1:0]                    rot;
        logic                          run_repeat;
        logic                          trig_prev;
        logic                          irq;
        logic                          conv_start;
    } asc_seq_s;

    asc_seq_s s_reg;
    asc_seq_s s_next;

    asc_conv_if conv ();

    asc_conv_timer #(
        .STATES    (CONV_STATES)
    ) u_timer (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .conv      (conv.timer),
        .core_data (core_data)
    );

    // Read word for a result pair
    function automatic logic [DATA_W-1:0] pair_word(input logic [RES_W-1:0] r, input logic f);
        logic [DATA_W-1:0] w;
        w                  = '0;
        w[R_HIGH_LSB +: 8] = r[RES_W-1:2];
        w[R_LOW_LSB +: 2]  = r[1:0];
        w[R_PAD_LSB +: 5]  = R_PAD_ONES;
        w[R_FLAG]          = f;
        return w;
    endfunction : pair_word

    logic              do_write;
    logic              sw_start;
    logic              trig_fall;
    logic              go;
    logic [CH_W-1:0]   first_ch;
    logic [1:0]        pair_idx;
    logic [1:0]        rd_pair;
    logic              rd_is_pair;
    logic              halt_abort;

    always_comb begin
        s_next            = s_reg;
        s_next.irq        = 1'b0;
        s_next.conv_start = 1'b0;
        halt_abort        = 1'b0;
        sw_start          = 1'b0;
        pair_idx          = '0;
        rd_pair           = '0;
        rd_is_pair        = 1'b0;

        // Address and data taken in either order
        if (s_reg.awready && s_axi_awvalid) begin
            s_next.awhave = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_reg.wready && s_axi_wvalid) begin
            s_next.whave = 1'b1;
            s_next.wdata = s_axi_wdata;
            s_next.wstrb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        do_write = s_reg.awhave && s_reg.whave && !s_reg.bvalid;
        if (do_write) begin
            s_next.awhave = 1'b0;
            s_next.whave  = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp  = RESP_OKAY;
            unique case (s_reg.awaddr)
                OFF_MODE_A: begin
                    if (s_reg.wstrb[0]) begin
                        s_next.scan      = s_reg.wdata[A_SCAN];
                        s_next.repeat_on = s_reg.wdata[A_REPEAT];
                        s_next.itm       = s_reg.wdata[A_ITM];
                        sw_start         = s_reg.wdata[A_START];
                    end
                end
                OFF_MODE_B: begin
                    if (s_reg.wstrb[0]) begin
                        s_next.ch_sel  = s_reg.wdata[B_CH_LSB +: CH_W];
                        s_next.trig_en = s_reg.wdata[B_TRIG_EN];
                        s_next.ref_en  = s_reg.wdata[B_REF_EN];
                    end
                end
                // Results take the write, keep content
                OFF_PAIR0, OFF_PAIR1, OFF_PAIR2, OFF_PAIR3: begin
                    s_next.bresp = RESP_OKAY;
                end
                default: begin
                    s_next.bresp = RESP_SLVERR;
                end
            endcase
        end

        // Read side effects act as the address is taken
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_reg.arready && s_axi_arvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = RESP_OKAY;
            s_next.rdata  = '0;
            unique case (s_axi_araddr)
                OFF_MODE_A: begin
                    s_next.rdata[A_SCAN]   = s_reg.scan;
                    s_next.rdata[A_REPEAT] = s_reg.repeat_on;
                    s_next.rdata[A_ITM]    = s_reg.itm;
                    s_next.rdata[A_BUSY]   = s_reg.busy;
                    s_next.rdata[A_EOC]    = s_reg.eoc;
                end
                OFF_MODE_B: begin
                    s_next.rdata[B_CH_LSB +: CH_W] = s_reg.ch_sel;
                    s_next.rdata[B_TRIG_EN]        = s_reg.trig_en;
                    s_next.rdata[B_REF_EN]         = s_reg.ref_en;
                end
                OFF_PAIR0, OFF_PAIR1, OFF_PAIR2, OFF_PAIR3: begin
                    rd_is_pair = 1'b1;
                    rd_pair    = 2'((s_axi_araddr - OFF_PAIR0) >> 2);
                end
                default: begin
                    s_next.rresp = RESP_SLVERR;
                end
            endcase
            if (rd_is_pair) begin
                s_next.rdata           = pair_word(s_reg.res[rd_pair], s_reg.stored[rd_pair]);
                s_next.stored[rd_pair] = 1'b0;
                s_next.eoc             = 1'b0;
            end
        end

        // Trigger pin taken as synchronous
        s_next.trig_prev = external_trigger_input_n;
        trig_fall = s_reg.trig_prev && !external_trigger_input_n;
        // Edges while busy are dropped, not queued
        go = (sw_start || (trig_fall && s_reg.trig_en && !s_reg.busy))
             && !halt_request;
        // Scan groups begin at input 0 or 4
        first_ch = s_next.scan ? {s_next.ch_sel[2], 2'b00} : s_next.ch_sel;

        if (go) begin
            // Restart drops a conversion under way
            s_next.run        = ST_RUN;
            s_next.busy       = 1'b1;
            s_next.cur_ch     = first_ch;
            s_next.rot        = '0;
            s_next.run_repeat = s_next.repeat_on;
            s_next.conv_start = 1'b1;
        end else begin
            unique case (s_reg.run)
                ST_IDLE: begin
                    s_next.busy = 1'b0;
                end
                ST_RUN: begin
                    if (halt_request) begin
                        halt_abort = 1'b1;
                        if (s_reg.run_repeat) begin
                            s_next.run = ST_HALT;
                        end else begin
                            s_next.run  = ST_IDLE;
                            s_next.busy = 1'b0;
                        end
                    end else if (conv.done) begin
                        // Fixed repeat rotates pairs; else n and n+4 share pair n
                        pair_idx = (s_reg.run_repeat && !s_reg.scan) ? s_reg.rot
                                                                    : s_reg.cur_ch[1:0];
                        s_next.res[pair_idx]    = conv.result;
                        s_next.stored[pair_idx] = 1'b1;
                        s_next.rot              = s_reg.rot + 1'b1;
                        if (s_reg.run_repeat && !s_reg.repeat_on) begin
                            s_next.run  = ST_IDLE;
                            s_next.busy = 1'b0;
                        end else if (s_reg.scan && s_reg.cur_ch[1:0] != s_reg.ch_sel[1:0]) begin
                            s_next.cur_ch     = s_reg.cur_ch + 1'b1;
                            s_next.conv_start = 1'b1;
                        end else begin
                            s_next.eoc = 1'b1;
                            s_next.irq = !(s_reg.run_repeat && !s_reg.scan && s_reg.itm)
                                         || (s_reg.rot == ROT_LAST);
                            if (s_reg.run_repeat) begin
                                s_next.cur_ch     = first_ch;
                                s_next.conv_start = 1'b1;
                            end else begin
                                s_next.run  = ST_IDLE;
                                s_next.busy = 1'b0;
                            end
                        end
                    end
                end
                ST_HALT: begin
                    // Busy held across halt in repeat modes
                    if (!halt_request) begin
                        s_next.run        = ST_RUN;
                        s_next.cur_ch     = first_ch;
                        s_next.rot        = '0;
                        s_next.conv_start = 1'b1;
                    end
                end
                default: begin
                    s_next.run  = ST_IDLE;
                    s_next.busy = 1'b0;
                end
            endcase
        end

        // Ready only while the slot is free
        s_next.awready = !s_next.awhave;
        s_next.wready  = !s_next.whave;
        s_next.arready = !s_next.rvalid;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s_reg        <= '0;
            s_reg.ch_sel <= CH_RESET;
            s_reg.run    <= ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign conv.start    = s_reg.conv_start;
    assign conv.abort    = halt_abort;
    assign conv.channel  = s_reg.cur_ch;

    assign s_axi_awready            = s_reg.awready;
    assign s_axi_wready             = s_reg.wready;
    assign s_axi_bresp              = s_reg.bresp;
    assign s_axi_bvalid             = s_reg.bvalid;
    assign s_axi_arready            = s_reg.arready;
    assign s_axi_rdata              = s_reg.rdata;
    assign s_axi_rresp              = s_reg.rresp;
    assign s_axi_rvalid             = s_reg.rvalid;
    assign core_channel             = conv.active_ch;
    assign core_sample              = conv.sampling;
    // Settle wait is left to software
    assign reference_switch_enable  = s_reg.ref_en;
    assign conversion_end_interrupt = s_reg.irq;
endmodule : asc_sequencer
`default_nettype wire

// File: dv/asc_core_model.sv
// Analogue core model: channel dependent result while sampling
`timescale 1ns/1ns
`default_nettype none
module asc_core_model (
    // Clock and sequencer side
    input  wire logic                        core_clk,
    input  wire logic                        core_sample,
    input  wire logic [asc_pkg::CH_W-1:0]    core_channel,
    // Result
    output logic [asc_pkg::RES_W-1:0]        core_data
);
    logic [9:0] churn = 10'h000;
    always @(posedge core_clk) churn <= churn + 10'h3B7;
    // Stale data is a running sum stepping by 10'h3B7 every clock
    assign core_data = core_sample ? {core_channel, ~core_channel, 4'h9} : churn;
endmodule : asc_core_model
`default_nettype wire

// File: dv/asc_sequencer_assertions.sv
// Checker: port timing of the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module asc_sequencer_checker #(parameter int CONV_STATES = 84) (
    // Clock, reset, system
    input wire logic core_clk, rstn, halt_request, core_sample,
    input wire logic reference_switch_enable, conversion_end_interrupt,
    // Register bus
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic s_axi_rvalid, s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic [7:0] cnt;
    // Restart writes reset the count
    always_ff @(posedge core_clk) cnt <= (!rstn || !core_sample || s_axi_bvalid) ? 8'h00 : cnt + 8'h01;
    sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_store; $past(core_sample, 2) && !$past(core_sample); endsequence
    property p_conv_len; conversion_end_interrupt |-> $past(cnt) == CONV_STATES; endproperty
    property p_irq_after; conversion_end_interrupt |-> s_store; endproperty
    property p_irq_pulse; conversion_end_interrupt |=> !conversion_end_interrupt; endproperty
    property p_halt_quiet; halt_request && $past(halt_request) |-> !core_sample && !conversion_end_interrupt; endproperty
    property p_halt_start; $rose(core_sample) |-> !$past(halt_request); endproperty
    property p_ref_wr; $changed(reference_switch_enable) |-> $rose(s_axi_bvalid); endproperty
    property p_wr_resp; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
    property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("bad length");
    a_irq_after: assert property (p_irq_after)
        else $error("late interrupt");
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("long interrupt");
    a_halt_quiet: assert property (p_halt_quiet)
        else $error("ran in halt");
    a_halt_start: assert property (p_halt_start)
        else $error("start in halt");
    a_ref_wr: assert property (p_ref_wr)
        else $error("reference changed alone");
    a_wr_resp: assert property (p_wr_resp)
        else $error("late bvalid");
    a_rd_lat: assert property (p_rd_lat)
        else $error("late rvalid");
    a_b_hold: assert property (p_b_hold)
        else $error("bvalid dropped");
    a_r_hold: assert property (p_r_hold)
        else $error("rvalid dropped");
endmodule : asc_sequencer_checker
bind asc_sequencer asc_sequencer_checker #(.CONV_STATES(CONV_STATES)) u_chk (.core_clk, .rstn,
    .halt_request, .core_sample, .reference_switch_enable, .conversion_end_interrupt, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_rdata);
`default_nettype wire

// File: dv/adc_sequencer_control_bench.sv
// Bench: conversion modes against an in-bench model
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer_control_bench;
    import asc_pkg::*;
    localparam int CS = 8;
    logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic trig_n = 1'b1, halt = 1'b0, awr, wrd, bv, arr, rv, smp, ref_en, irq;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat, d;
    logic [1:0] br, rr, r;
    logic [9:0] cdat;
    logic [2:0] cch, code;
    int fails = 0, tests_run = 0;
    always #5 clk = ~clk;
    asc_sequencer #(.CONV_STATES(CS)) i_dut (.core_clk(clk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .external_trigger_input_n(trig_n), .halt_request(halt), .core_data(cdat), .core_channel(cch),
        .core_sample(smp), .reference_switch_enable(ref_en), .conversion_end_interrupt(irq));
    asc_core_model i_core (.core_clk(clk), .core_sample(smp), .core_channel(cch), .core_data(cdat));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
        do begin
            @(posedge clk);
            if (awr && awv) awv <= 1'b0;
            if (wrd && wv) wv <= 1'b0;
        end while (!bv);
        r = br;
        bre <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        ara <= a; arv <= 1'b1; rre <= 1'b1;
        do begin
            @(posedge clk);
            if (arr && arv) arv <= 1'b0;
        end while (!rv);
        d = rdat; r = rr; rre <= 1'b0;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask : rc
    task automatic wirq(input int n, input int lim);
        while (n > 0 && lim > 0) begin
            @(posedge clk);
            lim--;
            if (irq === 1'b1) n--;
        end
        chk(n, 0);
    endtask : wirq
    task automatic quiet(input int c);
        int k = 0;
        repeat (c) begin @(posedge clk); if (irq !== 1'b0) k++; end
        chk(k, 0);
    endtask : quiet
    task automatic pulse;
        trig_n <= 1'b0;
        @(posedge clk) trig_n <= 1'b1;
    endtask : pulse
    // Pair word: result, five ones, stored flag
    function automatic logic [31:0] word(input logic [2:0] ch, input logic f);
        return {16'h0, ch, ~ch, 4'h9, 5'h1F, f};
    endfunction : word
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    initial begin repeat (20000) @(posedge clk); fails++; close_out(); end
    initial begin
        int ch, q[$];
        void'($urandom(51));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rc(OFF_MODE_A, 32'h0);
        rc(OFF_MODE_B, 32'h0);
        rc(8'h20, 32'h0); chk(r, RESP_SLVERR);
        $display("reset test done");
        wr(OFF_MODE_B, 32'h80);
        repeat (300) @(posedge clk);
        chk(ref_en, 1);
        for (int c = 0; c < 8; c++) begin
            wr(OFF_MODE_B, 32'h80 | c); wr(OFF_MODE_A, 32'h01);
            rd(OFF_MODE_A); chk(d[6], 1);
            wirq(1, 40); rc(OFF_MODE_A, 32'h80);
            rc(OFF_PAIR0 + 8'(4 * (c % 4)), word(3'(c), 1'b1));
            rc(OFF_MODE_A, 32'h0);
            rc(OFF_PAIR0 + 8'(4 * (c % 4)), word(3'(c), 1'b0));
        end
        $display("fixed single test done");
        code = 3'($urandom % 8);
        for (int i = 0; i <= code[1:0]; i++) q.push_back(code[2] * 4 + i);
        wr(OFF_MODE_B, 32'h80 | code); wr(OFF_MODE_A, 32'h03);
        wirq(1, 60); quiet(12); rc(OFF_MODE_A, 32'h82);
        foreach (q[i]) rc(OFF_PAIR0 + 8'(4 * i), word(3'(q[i]), 1'b1));
        $display("scan single test done");
        ch = $urandom % 8;
        wr(OFF_MODE_B, 32'h80 | ch); wr(OFF_MODE_A, 32'h0D);
        wirq(1, 60); quiet(35); wirq(1, 10);
        for (int i = 0; i < 4; i++) rc(OFF_PAIR0 + 8'(4 * i), word(3'(ch), 1'b1));
        wr(OFF_MODE_A, 32'h00); repeat (20) @(posedge clk);
        rd(OFF_MODE_A); chk(d[6], 0);
        wr(OFF_MODE_A, 32'h05); wirq(2, 24);
        wr(OFF_MODE_A, 32'h00); repeat (20) @(posedge clk);
        $display("fixed repeat test done");
        wr(OFF_MODE_B, 32'h81); wr(OFF_MODE_A, 32'h07);
        wirq(2, 50);
        halt <= 1'b1;
        quiet(6); chk(smp, 0);
        rd(OFF_MODE_A); chk(d[6], 1);
        halt <= 1'b0;
        wirq(1, 40);
        wr(OFF_MODE_A, 32'h00); repeat (30) @(posedge clk);
        wr(OFF_MODE_A, 32'h01); halt <= 1'b1;
        quiet(6); halt <= 1'b0;
        quiet(25);
        $display("halt test done");
        wr(OFF_MODE_B, 32'hA2);
        pulse(); repeat (2) @(posedge clk); pulse();
        quiet(6); wirq(1, 3);
        pulse(); repeat (2) @(posedge clk);
        wr(OFF_MODE_A, 32'h01);
        quiet(6); wirq(1, 8);
        wr(OFF_PAIR2, 32'hFFFF); chk(r, RESP_OKAY); rc(OFF_PAIR2, word(3'h2, 1'b1));
        $display("trigger test done");
        close_out();
    end
endmodule : adc_sequencer_control_bench
`default_nettype wire
